// File: core/omq_ahb_slave.sv
/*
  AHB-Lite slave front end: zero wait states, always OKAY.
  Assumes the register file answers rdAddr combinationally.
*/
`timescale 1ns/1ps
`include "omq_regs.svh"
module omq_ahb_slave (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Register file side
  output logic [31:0]      rdAddr,
  input  wire logic [31:0] rdData,
  output logic             wrEn,
  output logic [31:0]      wrAddr,
  output logic [31:0]      wrData
);
  logic addrPhase;
  logic wrPend;

  assign addrPhase = hsel && htrans[1] && hready && hsize == `OMQ_HSIZE_WORD;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rdAddr    = haddr;
  assign wrEn      = wrPend;
  assign wrData    = hwdata;

  // Write address held into the data phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
    end else begin
      wrPend <= addrPhase && hwrite;
      if (addrPhase && hwrite) begin
        wrAddr <= haddr;
      end
    end
  end

  // Read data captured at the end of the address phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdData;
    end
  end
endmodule

// File: core/omq_linker.sv
/*
  Ordered multicast queue linker: links a stored multicast chain onto
  several transmit queues, tracks per-port completion in an index buffer
  table and returns the chain to the free queue. Assumes the receive path,
  transmit queues and free queue manager sit outside on the same clock.
*/
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "omq_regs.svh"
module omq_linker #(
  parameter int NUM_PORTS = 15,
  parameter int ENTRIES   = 4,
  parameter int EW        = $clog2(ENTRIES)
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // AHB-Lite register bus
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Completed multicast frame
  input  wire logic               rxValid,
  input  wire omq_pkg::omq_rx_t   rxFrame,
  output logic                    rxReady,
  // External match bitmap
  input  wire omq_pkg::omq_map_t  externalMatchPort,
  // Transmit queue linking
  output logic                    linkValid,
  output omq_pkg::omq_map_t       linkMap,
  output omq_pkg::omq_addr_t      linkHead,
  output logic [EW-1:0]           linkEntry,
  // Frame appended behind the multicast data
  input  wire logic               appValid,
  input  wire omq_pkg::omq_port_t appPort,
  input  wire omq_pkg::omq_addr_t appHead,
  // Port finished the multicast data
  input  wire logic               doneValid,
  input  wire omq_pkg::omq_port_t donePort,
  input  wire logic [EW-1:0]      doneEntry,
  output logic                    contValid,
  output logic                    contFound,
  output omq_pkg::omq_addr_t      contPtr,
  // Buffer memory and free queue
  output logic                    memValid,
  output omq_pkg::omq_mem_t       memWrite,
  input  wire omq_pkg::omq_addr_t freeTop,
  output logic                    freeLoad,
  output omq_pkg::omq_addr_t      freeNewTop
);
  import omq_pkg::*;

  if (NUM_PORTS < 1 || NUM_PORTS > `OMQ_MAXP || ENTRIES < 2 || ENTRIES != 2 ** EW) begin : g_bad
    $error("omq_linker: unsupported NUM_PORTS or ENTRIES");
  end

  localparam omq_map_t PORT_MASK = omq_map_t'((1 << NUM_PORTS) - 1);

  function automatic omq_map_t portBit(input omq_port_t p);
    portBit = omq_map_t'(1) << p;
  endfunction

  function automatic logic inPorts(input omq_port_t p);
    inPorts = 32'(p) < NUM_PORTS;
  endfunction

  function automatic logic vlanHit(input logic [31:0] a);
    vlanHit = a >= `OMQ_REG_VLAN && a <= `OMQ_REG_VLAN + `OMQ_VLAN_SPAN;
  endfunction

  function automatic omq_port_t vlanIdx(input logic [31:0] a);
    logic [31:0] off;
    off     = a - `OMQ_REG_VLAN;
    vlanIdx = off[`OMQ_PW+1:2];
  endfunction

  // ==========================================================
  // Registers
  logic [1:0]    ctrl;
  omq_map_t      active;
  omq_map_t      vlan [`OMQ_MAXP];
  logic          wrEn;
  logic [31:0]   wrAddr;
  logic [31:0]   wrData;
  logic [31:0]   rdAddr;
  logic [31:0]   rdData;
  logic          select;
  logic          extOn;

  // Entry table standing for the index buffers
  logic [ENTRIES-1:0] entValid;
  omq_map_t      entTag [ENTRIES];
  omq_addr_t     entRet [ENTRIES];
  omq_addr_t     entTail [ENTRIES];
  omq_addr_t     fwdPtr [ENTRIES][`OMQ_MAXP];
  omq_map_t      fwdSet [ENTRIES];
  logic [EW-1:0] lastEntry [`OMQ_MAXP];
  omq_map_t      hasLast;

  omq_state_t    state;
  logic [EW-1:0] cur;
  logic [EW-1:0] slot;
  logic [EW-1:0] freeSel;
  logic          slotFree;
  logic          freePend;
  logic          linkFire;
  omq_map_t      baseMap;
  omq_map_t      destMap;
  omq_port_t     rxPort;
  omq_addr_t     rxHead;
  omq_addr_t     rxIdx;

  assign select = ctrl[`OMQ_CTRL_SEL];
  assign extOn  = ctrl[`OMQ_CTRL_EXT];
  assign rxPort = rxFrame.port;
  assign rxHead = rxFrame.head;
  assign rxIdx  = rxFrame.idx;

  omq_ahb_slave u_ahb (
    .clock     (clock),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rdAddr    (rdAddr),
    .rdData    (rdData),
    .wrEn      (wrEn),
    .wrAddr    (wrAddr),
    .wrData    (wrData)
  );

  // ==========================================================
  // Register file
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl   <= `OMQ_CTRL_RST;
      active <= '0;
    end else if (wrEn) begin
      if (wrAddr == `OMQ_REG_CTRL) begin
        ctrl <= wrData[1:0];
      end
      if (wrAddr == `OMQ_REG_ACTIVE) begin
        active <= wrData[`OMQ_MAXP-1:0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < `OMQ_MAXP; p++) begin
        vlan[p] <= '0;
      end
    end else if (wrEn && vlanHit(wrAddr)) begin
      vlan[vlanIdx(wrAddr)] <= wrData[`OMQ_MAXP-1:0];
    end
  end

  always_comb begin
    rdData = '0;
    if (rdAddr == `OMQ_REG_CTRL) begin
      rdData = 32'(ctrl);
    end else if (rdAddr == `OMQ_REG_ACTIVE) begin
      rdData = 32'(active);
    end else if (rdAddr == `OMQ_REG_STATUS) begin
      rdData = 32'(entValid) | (32'(linkMap) << `OMQ_STAT_MAP_LSB);
    end else if (vlanHit(rdAddr)) begin
      rdData = 32'(vlan[vlanIdx(rdAddr)]);
    end
  end

  // ==========================================================
  // Destination set and entry selection
  always_comb begin
    if (extOn) begin
      baseMap = externalMatchPort;
    end else begin
      baseMap = inPorts(rxPort) ? vlan[rxPort] : '0;
    end
    destMap = baseMap & active & PORT_MASK;
    if (!extOn) begin
      destMap = destMap & ~portBit(rxPort);
    end
  end

  always_comb begin
    slotFree = 1'b0;
    slot     = '0;
    freePend = 1'b0;
    freeSel  = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (!entValid[i]) begin
        slotFree = 1'b1;
        slot     = EW'(i);
      end
      if (entValid[i] && entTag[i] == '0) begin
        freePend = 1'b1;
        freeSel  = EW'(i);
      end
    end
  end

  // Freeing wins over new links
  assign rxReady  = select && state == OMQ_IDLE && slotFree && !freePend;
  assign linkFire = rxValid && rxReady;

  // ==========================================================
  // Index buffer table
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      entValid <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        entTag[i]  <= '0;
        entRet[i]  <= '0;
        entTail[i] <= '0;
      end
    end else begin
      if (doneValid) begin
        entTag[doneEntry] <= entTag[doneEntry] & ~portBit(donePort);
      end
      if (linkFire) begin
        entValid[slot] <= 1'b1;
        entTag[slot]   <= destMap;
        entRet[slot]   <= rxHead;
        entTail[slot]  <= rxFrame.tail;
      end
      if (state == OMQ_FREE_TOP) begin
        entValid[cur] <= 1'b0;
      end
    end
  end

  // Per-port continuation pointers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hasLast <= '0;
      for (int p = 0; p < `OMQ_MAXP; p++) begin
        lastEntry[p] <= '0;
      end
      for (int i = 0; i < ENTRIES; i++) begin
        fwdSet[i] <= '0;
        for (int p = 0; p < `OMQ_MAXP; p++) begin
          fwdPtr[i][p] <= '0;
        end
      end
    end else begin
      if (appValid && inPorts(appPort) && hasLast[appPort]
          && !fwdSet[lastEntry[appPort]][appPort]) begin
        fwdPtr[lastEntry[appPort]][appPort] <= appHead;
        fwdSet[lastEntry[appPort]][appPort] <= 1'b1;
      end
      if (state == OMQ_FREE_TOP) begin
        for (int p = 0; p < `OMQ_MAXP; p++) begin
          if (lastEntry[p] == cur) begin
            hasLast[p] <= 1'b0;
          end
        end
      end
      if (linkFire) begin
        fwdSet[slot] <= '0;
        for (int p = 0; p < `OMQ_MAXP; p++) begin
          if (destMap[p]) begin
            hasLast[p]   <= 1'b1;
            lastEntry[p] <= slot;
          end
        end
      end
    end
  end

  // Continuation answer to a finishing port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      contValid <= 1'b0;
      contFound <= 1'b0;
      contPtr   <= '0;
    end else begin
      contValid <= doneValid;
      if (doneValid && inPorts(donePort)) begin
        contPtr   <= fwdPtr[doneEntry][donePort];
        contFound <= fwdSet[doneEntry][donePort];
      end else if (doneValid) begin
        contPtr   <= '0;
        contFound <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Free sequence
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= OMQ_IDLE;
      cur   <= '0;
    end else begin
      unique case (state)
        OMQ_IDLE: begin
          if (freePend) begin
            cur   <= freeSel;
            state <= OMQ_FREE_PTR;
          end
        end
        OMQ_FREE_PTR: state <= OMQ_FREE_TOP;
        OMQ_FREE_TOP: state <= OMQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      freeLoad   <= 1'b0;
      freeNewTop <= '0;
    end else begin
      freeLoad <= state == OMQ_FREE_TOP;
      if (state == OMQ_FREE_TOP) begin
        freeNewTop <= entRet[cur];
      end
    end
  end

  // ==========================================================
  // Link and memory outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      linkValid <= 1'b0;
      linkMap   <= '0;
      linkHead  <= '0;
      linkEntry <= '0;
    end else begin
      linkValid <= linkFire;
      if (linkFire) begin
        linkMap   <= destMap;
        linkHead  <= rxHead;
        linkEntry <= slot;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      memValid <= 1'b0;
      memWrite <= '0;
    end else begin
      memValid <= linkFire || state == OMQ_FREE_PTR;
      if (linkFire) begin
        memWrite.addr <= rxIdx;
        memWrite.data <= `OMQ_IDX_MARK | 32'(destMap);
      end else if (state == OMQ_FREE_PTR) begin
        memWrite.addr <= entTail[cur];
        memWrite.data <= 32'(freeTop);
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence sPtrWrite;
    memValid && memWrite.addr == entTail[cur];
  endsequence

  sequence sTopLoad;
    freeLoad && freeNewTop == entRet[cur];
  endsequence

  a_free_order: assert property (
    state == OMQ_FREE_PTR |=> sPtrWrite ##1 sTopLoad)
    else $error("free chain order broken");

  a_free_tags: assert property (
    state == OMQ_FREE_PTR |-> entTag[cur] == '0)
    else $error("freeing with ports outstanding");

  a_select_gate: assert property (
    !select |=> !linkValid)
    else $error("accepting while deselected");

  a_link_map: assert property (
    linkFire |=> linkValid && linkMap == $past(destMap))
    else $error("link map wrong");

  a_link_head: assert property (
    linkFire |=> linkHead == $past(rxHead))
    else $error("link head wrong");

  a_index_mark: assert property (
    linkFire |=> memValid && memWrite.data[`OMQ_IDX_BIT] && memWrite.addr == $past(rxIdx))
    else $error("index buffer not marked");

  a_active_only: assert property (
    linkValid |-> (linkMap & $past(active)) == linkMap)
    else $error("inactive port linked");

  a_no_echo: assert property (
    linkFire && !extOn |=> (linkMap & portBit($past(rxPort))) == '0)
    else $error("frame echoed to source");
endmodule

// File: core/omq_pkg.sv
/*
  Types shared by the ordered multicast queue linker.
  Assumes omq_regs.svh is on the include path.
*/
`include "omq_regs.svh"
package omq_pkg;
  typedef logic [`OMQ_MAXP-1:0] omq_map_t;
  typedef logic [`OMQ_AW-1:0]   omq_addr_t;
  typedef logic [`OMQ_PW-1:0]   omq_port_t;

  // Completed multicast frame handed over by the receive path
  typedef struct packed {
    omq_port_t port;
    omq_addr_t head;
    omq_addr_t tail;
    omq_addr_t idx;
  } omq_rx_t;

  // One word written to buffer memory
  typedef struct packed {
    omq_addr_t   addr;
    logic [31:0] data;
  } omq_mem_t;

  typedef enum {OMQ_IDLE, OMQ_FREE_PTR, OMQ_FREE_TOP} omq_state_t;
endpackage

// File: core/omq_regs.svh
/*
  Register map, field positions and fixed widths of the ordered multicast
  queue linker. Assumes it is included by the package and the design files.
*/
// Function
// - Once a multicast frame is fully queued, attach it to every chosen transmit queue.
// - Without external matching, destinations are active ports in receiving port's VLAN map.
// - With external matching, destinations are active ports in the external bitmap.
// - Each chosen queue's forward pointer is set to the shared chain head.
// - Index buffer holds one continuation pointer per port, updated as frames follow.
// - Index buffer holds a tag recording which targeted ports still owe transmission.
// - Multicast buffers are freed only after the last port tag clears.
// - Chain head is kept as the index buffer's return address.
// - Free by writing free-queue top into chain tail, then return address becomes top.
// - Internal matching never sends a frame back out of its receiving port.
// - Ordered multicast handling works only while its select bit is set.
// - At end of a multicast frame an index buffer is appended to the receive queue.
// - An index buffer is marked by setting bit 23 of its tag field.
`ifndef OMQ_REGS_SVH
`define OMQ_REGS_SVH

`define OMQ_MAXP         15
`define OMQ_PW           4
`define OMQ_AW           22
`define OMQ_REG_CTRL     32'h0000_0000
`define OMQ_REG_ACTIVE   32'h0000_0004
`define OMQ_REG_STATUS   32'h0000_0008
`define OMQ_REG_VLAN     32'h0000_0040
`define OMQ_VLAN_SPAN    32'h0000_0038
`define OMQ_CTRL_SEL     0
`define OMQ_CTRL_EXT     1
`define OMQ_CTRL_RST     2'h0
`define OMQ_STAT_MAP_LSB 16
`define OMQ_IDX_BIT      23
`define OMQ_IDX_MARK     (32'h1 << `OMQ_IDX_BIT)
`define OMQ_HSIZE_WORD   3'h2

`endif

// File: tb/omq_tx_model.sv
/*
  Far-side model: free queue manager, external match logic and a recorder
  of buffer memory writes. Assumes the linker's clock and reset.
*/
`timescale 1ns/1ps
module omq_tx_model #(
  parameter logic [21:0] TOP_INIT = 22'h3a5a5
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // External match
  input  wire omq_pkg::omq_port_t rxPort,
  input  wire omq_pkg::omq_map_t  extCfg,
  output omq_pkg::omq_map_t       extMap,
  // Memory and free queue
  input  wire logic               memValid,
  input  wire omq_pkg::omq_mem_t  memWrite,
  input  wire logic               freeLoad,
  input  wire omq_pkg::omq_addr_t freeNewTop,
  output omq_pkg::omq_addr_t      freeTop,
  output omq_pkg::omq_mem_t       lastMem,
  output logic [7:0]              freeCnt
);
  import omq_pkg::*;

  // ==========================================
  // Routing drops the receiving port itself
  assign extMap = extCfg & ~(omq_map_t'(1) << rxPort);

  // ==========================================
  // Free queue top moves when a chain comes back
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      freeTop <= TOP_INIT;
      freeCnt <= 8'h00;
    end else if (freeLoad) begin
      freeTop <= freeNewTop;
      freeCnt <= freeCnt + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastMem <= '0;
    end else if (memValid) begin
      lastMem <= memWrite;
    end
  end
endmodule

// File: tb/testbench.sv
/*
  Self-checking bench of the ordered multicast queue linker.
  Assumes omq_regs.svh on the include path and the far-side model.
*/
`timescale 1ns/1ps
`include "omq_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  import omq_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = '0;
  wire logic   hready;
  logic        hreadyout, hresp;
  logic [31:0] hrdata;
  logic        rxValid = 1'b0;
  omq_rx_t     rxFrame = '0;
  logic        rxReady;
  omq_map_t    extMap, linkMap;
  omq_map_t    extCfg = '0;
  logic        linkValid, contValid, contFound, memValid, freeLoad;
  omq_addr_t   linkHead, contPtr, freeTop, freeNewTop;
  logic [1:0]  linkEntry, ent;
  logic [1:0]  doneEntry = 2'h0;
  logic        appValid = 1'b0;
  logic        doneValid = 1'b0;
  omq_port_t   appPort = '0;
  omq_port_t   donePort = '0;
  omq_addr_t   appHead = '0;
  omq_mem_t    memWrite, lastMem;
  logic [7:0]  freeCnt;
  int          error_cnt = 0;
  int          n_compared = 0;
  omq_rx_t     f1, f2, f3;

  assign hready = hreadyout;
  always #4 clock = ~clock;

  omq_linker #(.NUM_PORTS(15), .ENTRIES(4)) omq_linker_i (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxValid(rxValid),
    .rxFrame(rxFrame), .rxReady(rxReady), .externalMatchPort(extMap),
    .linkValid(linkValid), .linkMap(linkMap), .linkHead(linkHead),
    .linkEntry(linkEntry), .appValid(appValid), .appPort(appPort), .appHead(appHead),
    .doneValid(doneValid), .donePort(donePort), .doneEntry(doneEntry),
    .contValid(contValid), .contFound(contFound), .contPtr(contPtr),
    .memValid(memValid), .memWrite(memWrite), .freeTop(freeTop),
    .freeLoad(freeLoad), .freeNewTop(freeNewTop));

  omq_tx_model omq_tx_model_i (
    .clock(clock), .rst(rst), .rxPort(rxFrame.port), .extCfg(extCfg), .extMap(extMap),
    .memValid(memValid), .memWrite(memWrite), .freeLoad(freeLoad),
    .freeNewTop(freeNewTop), .freeTop(freeTop), .lastMem(lastMem), .freeCnt(freeCnt));

  // ==========================================
  // Verdict and bounded waits
  task automatic final_report();
    $display("Compared %0d values, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic fail_out();
    error_cnt++;
    final_report();
  endtask

  task automatic wait_ready();
    for (int n = 0; n < 50; n++) begin
      @(posedge clock);
      if (hready === 1'b1) return;
    end
    fail_out();
  endtask

  // ==========================================
  // Register bus transfers
  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= `OMQ_HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask

  // ==========================================
  // Frame, append and completion traffic
  task automatic send(input omq_rx_t f, input omq_map_t m);
    @(posedge clock);
    rxFrame <= f;
    rxValid <= 1'b1;
    for (int n = 0; n <= 20; n++) begin
      @(posedge clock);
      if (n == 20) fail_out();
      if (rxReady === 1'b1) break;
    end
    rxValid <= 1'b0;
    #1;
    `CHK(linkValid, 1'b1)
    `CHK(linkMap, m)
    `CHK(linkHead, f.head)
    `CHK(memValid, 1'b1)
    `CHK(memWrite, {f.idx, `OMQ_IDX_MARK | 32'(m)})
    ent = linkEntry;
  endtask

  task automatic app(input omq_port_t p, input omq_addr_t h);
    @(posedge clock);
    appValid <= 1'b1;
    appPort <= p;
    appHead <= h;
    @(posedge clock);
    appValid <= 1'b0;
  endtask

  task automatic done(input omq_port_t p, input logic f, input omq_addr_t c);
    @(posedge clock);
    doneValid <= 1'b1;
    donePort <= p;
    doneEntry <= ent;
    @(posedge clock);
    doneValid <= 1'b0;
    #1;
    `CHK(contValid, 1'b1)
    `CHK(contFound, f)
    if (f) `CHK(contPtr, c)
  endtask

  task automatic drain(input omq_map_t m, input omq_port_t ap, input omq_rx_t f);
    omq_addr_t  top;
    logic [7:0] cnt;
    top = freeTop;
    cnt = freeCnt;
    for (int p = 0; p < 15; p++) begin
      if (m[p]) begin
        `CHK(freeCnt, cnt)
        done(omq_port_t'(p), omq_port_t'(p) == ap, appHead);
      end
    end
    for (int n = 0; n <= 10; n++) begin
      @(posedge clock);
      #1;
      if (n == 10) fail_out();
      if (freeCnt !== cnt) break;
    end
    `CHK(lastMem, {f.tail, 32'(top)})
    `CHK(freeTop, f.head)
  endtask

  // ==========================================
  // Main sequence
  initial begin
    #500000;
    fail_out();
  end

  initial begin
    f1 = '{port: 4'h3, head: 22'h01000, tail: 22'h01003, idx: 22'h01004};
    f2 = '{port: 4'h9, head: 22'h02000, tail: 22'h02001, idx: 22'h02002};
    f3 = '{port: 4'h1, head: 22'h03000, tail: 22'h03000, idx: 22'h03001};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK(rxReady, 1'b0)
    rd_chk(`OMQ_REG_CTRL, 32'h0);
    wr(`OMQ_REG_ACTIVE, 32'h7f7f);
    wr(`OMQ_REG_VLAN + 32'h0c, 32'h00ff);
    wr(32'h0000_0100, 32'hffff);
    rd_chk(32'h0000_0100, 32'h0);
    rd_chk(`OMQ_REG_VLAN + 32'h0c, 32'h00ff);
    rd_chk(`OMQ_REG_ACTIVE, 32'h7f7f);
    // Select bit clear: frame must wait
    @(posedge clock);
    rxFrame <= f1;
    rxValid <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK(rxReady, 1'b0)
    `CHK(linkValid, 1'b0)
    rxValid <= 1'b0;
    // Internal matching, receiving port and inactive ports dropped
    wr(`OMQ_REG_CTRL, 32'h1);
    send(f1, 15'h0077);
    rd_chk(`OMQ_REG_STATUS, 32'h0077_0001);
    app(4'h5, 22'h00123);
    done(4'hf, 1'b0, 22'h0);
    drain(15'h0077, 4'h5, f1);
    // External matching limited to active ports
    wr(`OMQ_REG_CTRL, 32'h3);
    wr(`OMQ_REG_ACTIVE, 32'h0ff0);
    extCfg <= 15'h0f0f;
    send(f2, 15'h0d00);
    drain(15'h0d00, 4'hf, f2);
    // Empty destination set returns at once
    extCfg <= 15'h0000;
    send(f3, 15'h0000);
    drain(15'h0000, 4'hf, f3);
    final_report();
  end
endmodule
